// [rstc_map.vh]
`ifndef RSTC_MAP_VH
`define RSTC_MAP_VH

// ==========================================================
// register offsets (byte addresses)
`define RSTC_THR_OFS 8'h00
`define RSTC_CTRL_OFS 8'h04
`define RSTC_WATCHDOG_CONTROL_REG_OFS 8'h08
`define RSTC_STAT_OFS 8'h0C
`define RSTC_PORT_OFS 8'h10
`define RSTC_CORE_OFS 8'h14

// ==========================================================
// field positions
`define RSTC_WRF_BIT 0
`define RSTC_LRF_BIT 1
`define RSTC_SUPPLY_DIP_FLAG_BIT 2
`define RSTC_KEEP_BIT 7
`define RSTC_PDF_BIT 4
`define RSTC_TO_BIT 5
`define RSTC_WKEY_HI 7
`define RSTC_WKEY_LO 3
`define RSTC_INTEN_BIT 0
`define RSTC_TMRON_BIT 1

// ==========================================================
// reset values and valid codes
`define RSTC_THR_POR 8'h55
`define RSTC_WATCHDOG_CONTROL_REG_POR 8'h53
`define RSTC_PORT_POR 8'hFF
`define RSTC_THR_OK0 8'h55
`define RSTC_THR_OK1 8'h33
`define RSTC_THR_OK2 8'h99
`define RSTC_THR_OK3 8'hAA
`define RSTC_WKEY_OK0 5'h0A
`define RSTC_WKEY_OK1 5'h15

// ==========================================================
// timing
`define RSTC_PCLK_HZ 250000000
`define RSTC_PCLK_NS 4
`define RSTC_SLOW_HZ 32000
`define RSTC_DIP_QUAL_NS 100000
`define RSTC_TRIG_TICKS 3
`define RSTC_HOLD_CYC 4

`endif

// [rstc_sync.v]
`timescale 1ns/1ns
// ==========================================================
// two-stage synchroniser for pin inputs
module rstc_sync #(
  parameter W = 2
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_q;

  // first stage feeds the second stage only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// [rstc_dly.v]
`timescale 1ns/1ns
// ==========================================================
// delays a reset request by a fixed number of slow ticks
module rstc_dly #(
  parameter TICKS = 3
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // slow enable and request
  input wire tick,
  input wire req,
  // one-cycle trigger
  output reg fire_q
);

  reg busy_q;
  reg [3:0] cnt_q;

  // the first tick lands anywhere in a slow period, so three ticks give 2 to 3 periods
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      fire_q <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      if (busy_q) begin
        if (tick) begin
          if (cnt_q == TICKS[3:0] - 4'h1) begin
            busy_q <= 1'b0;
            fire_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
      end else if (req && !fire_q) begin
        busy_q <= 1'b1;
        cnt_q <= 4'h0;
      end
    end
  end

endmodule

// [rstc_ctrl.v]
`timescale 1ns/1ns
`include "rstc_map.vh"

module rstc_ctrl #(
  parameter SLOW_DIV = `RSTC_PCLK_HZ / `RSTC_SLOW_HZ,
  parameter DIP_QUAL_CYC = (`RSTC_DIP_QUAL_NS + `RSTC_PCLK_NS - 1) / `RSTC_PCLK_NS,
  parameter HOLD_CYC = `RSTC_HOLD_CYC,
  parameter TRIG_TICKS = `RSTC_TRIG_TICKS
) (
  // clock and power-on reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // analogue detector and watchdog counter
  input wire supply_low,
  input wire wdt_overflow,
  // cpu core status
  input wire sleep_idle,
  input wire halt_exec,
  input wire wdt_clear_exec,
  // reset outputs
  output reg sys_rst_n_q,
  output reg pc_sp_clr_q,
  output reg wdt_cnt_clr_q,
  // preset register values
  output reg [7:0] port_data_q,
  output reg [7:0] port_dir_q,
  output reg int_en_q,
  output reg timer_on_q,
  output reg [7:0] wdt_ctrl_q,
  output reg idle_sysclk_keep_q
);

  // ==========================================================
  // declarations
  reg [7:0] thr_code_q;
  reg supply_dip_flag_q;
  reg thr_fault_flag_q;
  reg wdt_fault_flag_q;
  reg timeout_flag_q;
  reg powerdown_flag_q;
  reg [15:0] div_q;
  reg slow_tick_q;
  reg [31:0] qual_q;
  reg lvr_req_q;
  reg ovf_d_q;
  reg [3:0] hold_q;
  reg [31:0] rd_d;
  reg hit_d;
  wire [1:0] pin_s;
  wire low_s;
  wire ovf_s;
  wire [2:0] req;
  wire [2:0] fire;
  wire thr_bad;
  wire key_bad;
  wire ovf_rise;
  wire wdt_norm;
  wire wdt_sleep;
  wire full_rst;
  wire wr_en;
  wire wr_thr;
  wire wr_ctrl;
  wire wr_watchdog_control_reg;
  wire wr_port;
  wire wr_core;
  wire [4:0] wkey;

  // ==========================================================
  // pin synchronisers
  rstc_sync #(
    .W(2)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({wdt_overflow, supply_low}),
    .q(pin_s)
  );

  assign low_s = pin_s[0];
  assign ovf_s = pin_s[1];

  // ==========================================================
  // slow oscillator tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
      slow_tick_q <= 1'b0;
    end else begin
      if (div_q == SLOW_DIV[15:0] - 16'h0001) begin
        div_q <= 16'h0000;
        slow_tick_q <= 1'b1;
      end else begin
        div_q <= div_q + 16'h0001;
        slow_tick_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // undervoltage qualification
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_q <= 32'h0000_0000;
      lvr_req_q <= 1'b0;
    end else begin
      lvr_req_q <= 1'b0;
      if (!low_s || sleep_idle) begin
        qual_q <= 32'h0000_0000;
      end else if (qual_q < DIP_QUAL_CYC) begin
        qual_q <= qual_q + 32'h0000_0001;
      end else if (qual_q == DIP_QUAL_CYC) begin
        // only dips longer than qualifying time
        qual_q <= qual_q + 32'h0000_0001;
        lvr_req_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // code checks
  // four valid threshold codes
  assign thr_bad = (thr_code_q != `RSTC_THR_OK0) && (thr_code_q != `RSTC_THR_OK1) &&
                   (thr_code_q != `RSTC_THR_OK2) && (thr_code_q != `RSTC_THR_OK3);
  assign wkey = wdt_ctrl_q[`RSTC_WKEY_HI:`RSTC_WKEY_LO];
  assign key_bad = (wkey != `RSTC_WKEY_OK0) && (wkey != `RSTC_WKEY_OK1);

  assign req = {key_bad, thr_bad, lvr_req_q};

  // ==========================================================
  // delayed triggers: dip, threshold code, watchdog key
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_dly
      rstc_dly #(
        .TICKS(TRIG_TICKS)
      ) u_dly (
        .clk(pclk),
        .rst_n(presetn),
        .tick(slow_tick_q),
        .req(req[gi]),
        .fire_q(fire[gi])
      );
    end
  endgenerate

  // ==========================================================
  // watchdog time-out
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_d_q <= 1'b0;
    end else begin
      ovf_d_q <= ovf_s;
    end
  end

  assign ovf_rise = ovf_s && !ovf_d_q;
  assign wdt_norm = ovf_rise && !sleep_idle;
  assign wdt_sleep = ovf_rise && sleep_idle;

  assign full_rst = fire[0] || fire[1] || fire[2] || wdt_norm;

  // ==========================================================
  // merged reset and hold
  // async assert, sync release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 4'h0;
      sys_rst_n_q <= 1'b0;
      wdt_cnt_clr_q <= 1'b1;
      pc_sp_clr_q <= 1'b1;
    end else begin
      if (full_rst) begin
        hold_q <= HOLD_CYC[3:0];
        sys_rst_n_q <= 1'b0;
        wdt_cnt_clr_q <= 1'b1;
        pc_sp_clr_q <= 1'b1;
      end else if (hold_q != 4'h0) begin
        hold_q <= hold_q - 4'h1;
      end else begin
        sys_rst_n_q <= 1'b1;
        wdt_cnt_clr_q <= 1'b0;
        // sleep time-out clears pc and sp only
        pc_sp_clr_q <= wdt_sleep;
      end
    end
  end

  // ==========================================================
  // apb decode
  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
  assign wr_thr = wr_en && (paddr == `RSTC_THR_OFS);
  assign wr_ctrl = wr_en && (paddr == `RSTC_CTRL_OFS);
  assign wr_watchdog_control_reg = wr_en && (paddr == `RSTC_WATCHDOG_CONTROL_REG_OFS);
  assign wr_port = wr_en && (paddr == `RSTC_PORT_OFS);
  assign wr_core = wr_en && (paddr == `RSTC_CORE_OFS);

  always @* begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      `RSTC_THR_OFS: begin
        rd_d[7:0] = thr_code_q;
      end
      `RSTC_CTRL_OFS: begin
        rd_d[`RSTC_KEEP_BIT] = idle_sysclk_keep_q;
        rd_d[`RSTC_SUPPLY_DIP_FLAG_BIT] = supply_dip_flag_q;
        rd_d[`RSTC_LRF_BIT] = thr_fault_flag_q;
        rd_d[`RSTC_WRF_BIT] = wdt_fault_flag_q;
      end
      `RSTC_WATCHDOG_CONTROL_REG_OFS: begin
        rd_d[7:0] = wdt_ctrl_q;
      end
      `RSTC_STAT_OFS: begin
        rd_d[`RSTC_TO_BIT] = timeout_flag_q;
        rd_d[`RSTC_PDF_BIT] = powerdown_flag_q;
      end
      `RSTC_PORT_OFS: begin
        rd_d[15:0] = {port_dir_q, port_data_q};
      end
      `RSTC_CORE_OFS: begin
        rd_d[`RSTC_INTEN_BIT] = int_en_q;
        rd_d[`RSTC_TMRON_BIT] = timer_on_q;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // zero-wait slave: answer is ready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
      if (psel && !penable) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr_q <= !hit_d;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // threshold code register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_code_q <= `RSTC_THR_POR;
    end else if (fire[1]) begin
      thr_code_q <= `RSTC_THR_POR;
    end else if (wr_thr) begin
      // dip and watchdog resets leave the code alone
      thr_code_q <= pwdata[7:0];
    end
  end

  // ==========================================================
  // cause flags, hardware set beats software clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_dip_flag_q <= 1'b0;
      thr_fault_flag_q <= 1'b0;
      wdt_fault_flag_q <= 1'b0;
    end else begin
      supply_dip_flag_q <= fire[0] ||
        (supply_dip_flag_q && !(wr_ctrl && !pwdata[`RSTC_SUPPLY_DIP_FLAG_BIT]));
      thr_fault_flag_q <= fire[1] ||
        (thr_fault_flag_q && !(wr_ctrl && !pwdata[`RSTC_LRF_BIT]));
      wdt_fault_flag_q <= fire[2] ||
        (wdt_fault_flag_q && !(wr_ctrl && !pwdata[`RSTC_WRF_BIT]));
    end
  end

  // ==========================================================
  // time-out and power-down flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag_q <= 1'b0;
      powerdown_flag_q <= 1'b0;
    end else begin
      // time-out set by any watchdog time-out
      if (ovf_rise) begin
        timeout_flag_q <= 1'b1;
      end
      if (wdt_sleep || halt_exec) begin
        powerdown_flag_q <= 1'b1;
      end else if (wdt_clear_exec) begin
        powerdown_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // preset registers, restored by every full reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_q <= `RSTC_PORT_POR;
      port_dir_q <= `RSTC_PORT_POR;
      int_en_q <= 1'b0;
      timer_on_q <= 1'b0;
      wdt_ctrl_q <= `RSTC_WATCHDOG_CONTROL_REG_POR;
      idle_sysclk_keep_q <= 1'b0;
    end else if (full_rst) begin
      port_data_q <= `RSTC_PORT_POR;
      port_dir_q <= `RSTC_PORT_POR;
      int_en_q <= 1'b0;
      timer_on_q <= 1'b0;
      wdt_ctrl_q <= `RSTC_WATCHDOG_CONTROL_REG_POR;
      idle_sysclk_keep_q <= 1'b0;
    end else begin
      if (wr_port) begin
        port_data_q <= pwdata[7:0];
        port_dir_q <= pwdata[15:8];
      end
      if (wr_core) begin
        int_en_q <= pwdata[`RSTC_INTEN_BIT];
        timer_on_q <= pwdata[`RSTC_TMRON_BIT];
      end
      if (wr_watchdog_control_reg) begin
        wdt_ctrl_q <= pwdata[7:0];
      end
      if (wr_ctrl) begin
        idle_sysclk_keep_q <= pwdata[`RSTC_KEEP_BIT];
      end
    end
  end

  // ==========================================================
  // notes on pc and stack
  // one strobe serves pc and sp, the stack top is index zero
  // a sleep time-out inside a hold window is absorbed: the
  // full reset already clears pc and sp.

endmodule

// [rstc_ctrl_assertions.sv]
`timescale 1ns/1ns
`include "rstc_map.vh"
// ==========================================================
// port checker for the reset controller
module rstc_ctrl_assertions (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata_q,
  input wire pready_q,
  input wire pslverr_q,
  // reset outputs and preset register values
  input wire sys_rst_n_q,
  input wire pc_sp_clr_q,
  input wire wdt_cnt_clr_q,
  input wire [7:0] port_data_q,
  input wire [7:0] port_dir_q,
  input wire int_en_q,
  input wire timer_on_q,
  input wire [7:0] wdt_ctrl_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = paddr inside {`RSTC_THR_OFS, `RSTC_CTRL_OFS, `RSTC_WATCHDOG_CONTROL_REG_OFS, `RSTC_STAT_OFS, `RSTC_PORT_OFS,
    `RSTC_CORE_OFS};
  sequence s_hold;
    !sys_rst_n_q [*5] ##1 sys_rst_n_q;
  endsequence
  sequence s_presets;
    port_data_q == 8'hFF && port_dir_q == 8'hFF && !int_en_q && !timer_on_q && wdt_ctrl_q == 8'h53;
  endsequence
  a_hold_width: assert property ($fell(sys_rst_n_q) |-> s_hold)
    else $error("internal reset width wrong");
  a_release_presets: assert property ($rose(sys_rst_n_q) |-> s_presets)
    else $error("presets missing at reset release");
  a_clear_in_reset: assert property (!sys_rst_n_q |-> pc_sp_clr_q && wdt_cnt_clr_q)
    else $error("pc or watchdog clear missing in reset");
  a_count_start: assert property ($rose(sys_rst_n_q) |-> !wdt_cnt_clr_q && !pc_sp_clr_q)
    else $error("watchdog counter not released");
  a_sleep_pulse: assert property (sys_rst_n_q && pc_sp_clr_q |=> !pc_sp_clr_q)
    else $error("pc clear pulse too long");
  a_zero_wait: assert property (psel && !penable |=> pready_q)
    else $error("apb answer late");
  a_ready_once: assert property (pready_q |=> !pready_q)
    else $error("apb ready held");
  a_rsvd_zero: assert property (pready_q && !pwrite && paddr == `RSTC_CTRL_OFS |-> prdata_q[6:3] == 4'h0)
    else $error("reserved cause bits not zero");
  a_err_unmapped: assert property (pready_q |-> pslverr_q == !mapped)
    else $error("slave error wrong");
endmodule

bind rstc_ctrl rstc_ctrl_assertions rstc_ctrl_assertions_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata_q, .pready_q, .pslverr_q, .sys_rst_n_q, .pc_sp_clr_q, .wdt_cnt_clr_q, .port_data_q, .port_dir_q,
  .int_en_q, .timer_on_q, .wdt_ctrl_q);

// [rstc_far_model.sv]
`timescale 1ns/1ns
// ==========================================================
// supply comparator and watchdog counter stand-in
module rstc_far_model (
  // clock
  input wire pclk,
  // detector levels
  output reg supply_low,
  output reg wdt_overflow
);
  initial begin
    supply_low = 1'b0;
    wdt_overflow = 1'b0;
  end
  // comparator has no hysteresis here, so a dip is a clean level
  task automatic dip(input int n);
    @(posedge pclk);
    supply_low <= 1'b1;
    repeat (n) @(posedge pclk);
    supply_low <= 1'b0;
  endtask
  task automatic overflow(input int n);
    @(posedge pclk);
    wdt_overflow <= 1'b1;
    repeat (n) @(posedge pclk);
    wdt_overflow <= 1'b0;
  endtask
endmodule

// [mcu_reset_controller_tb_top.sv]
`timescale 1ns/1ns
`include "rstc_map.vh"
// ==========================================================
// directed bench over apb
module mcu_reset_controller_tb_top;
  reg pclk = 1'b0;
  reg presetn;
  reg psel;
  reg penable;
  reg pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  reg sleep_idle;
  reg halt_exec;
  reg wdt_clear_exec;
  wire [31:0] prdata_q;
  wire pready_q, pslverr_q, supply_low, wdt_overflow, sys_rst_n_q, pc_sp_clr_q, wdt_cnt_clr_q;
  wire [7:0] port_data_q, port_dir_q, wdt_ctrl_q;
  wire int_en_q, timer_on_q, idle_sysclk_keep_q;
  int n_fail = 0;
  int check_count = 0;
  int rst_seen = 0;
  int pulse_seen = 0;
  reg last_err;
  reg [7:0] codes [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};

  always #2 pclk = ~pclk;

  rstc_ctrl #(.SLOW_DIV(8), .DIP_QUAL_CYC(10)) rstc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .supply_low(supply_low), .wdt_overflow(wdt_overflow),
    .sleep_idle(sleep_idle), .halt_exec(halt_exec), .wdt_clear_exec(wdt_clear_exec),
    .sys_rst_n_q(sys_rst_n_q), .pc_sp_clr_q(pc_sp_clr_q), .wdt_cnt_clr_q(wdt_cnt_clr_q),
    .port_data_q(port_data_q), .port_dir_q(port_dir_q), .int_en_q(int_en_q), .timer_on_q(timer_on_q),
    .wdt_ctrl_q(wdt_ctrl_q), .idle_sysclk_keep_q(idle_sysclk_keep_q));
  rstc_far_model rstc_far_model_i (.pclk(pclk), .supply_low(supply_low), .wdt_overflow(wdt_overflow));

  always @(negedge sys_rst_n_q) if (presetn) rst_seen++;
  always @(posedge pclk) if (sys_rst_n_q === 1'b1 && pc_sp_clr_q === 1'b1) pulse_seen++;

  // ==========================================================
  // bus tasks
  task automatic xfer(input bit w, input [7:0] a, input [31:0] d, output [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready_q !== 1'b1);
    r = prdata_q;
    last_err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input [7:0] a, input [31:0] exp);
    reg [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    reg [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic settle();
    repeat (100) @(posedge pclk);
  endtask
  task automatic print_verdict();
    $display("fails=%0d checks=%0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end

  // ==========================================================
  // tests
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    sleep_idle <= 1'b0;
    halt_exec <= 1'b0;
    wdt_clear_exec <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RSTC_THR_OFS, 32'h55);
    rd(`RSTC_CTRL_OFS, 32'h0);
    rd(`RSTC_WATCHDOG_CONTROL_REG_OFS, 32'h53);
    rd(`RSTC_STAT_OFS, 32'h0);
    rd(`RSTC_PORT_OFS, 32'hFFFF);
    rd(`RSTC_CORE_OFS, 32'h0);
    rd(8'h20, 32'h0);
    chk(last_err, 1'b1);
    $display("test power-on done");
    foreach (codes[i]) begin
      wr(`RSTC_THR_OFS, codes[i]);
      rd(`RSTC_THR_OFS, codes[i]);
    end
    settle();
    chk(rst_seen, 0);
    rstc_far_model_i.dip(10);
    settle();
    chk(rst_seen, 0);
    rstc_far_model_i.dip(40);
    settle();
    chk(rst_seen, 1);
    rd(`RSTC_CTRL_OFS, 32'h4);
    rd(`RSTC_THR_OFS, 32'hAA);
    wr(`RSTC_CTRL_OFS, 32'h7F);
    rd(`RSTC_CTRL_OFS, 32'h4);
    wr(`RSTC_CTRL_OFS, 32'h0);
    rd(`RSTC_CTRL_OFS, 32'h0);
    wr(`RSTC_CTRL_OFS, 32'h80);
    rd(`RSTC_CTRL_OFS, 32'h80);
    chk(idle_sysclk_keep_q, 1'b1);
    sleep_idle <= 1'b1;
    rstc_far_model_i.dip(40);
    settle();
    sleep_idle <= 1'b0;
    chk(rst_seen, 1);
    $display("test supply done");
    wr(`RSTC_THR_OFS, 32'h12);
    settle();
    chk(rst_seen, 2);
    rd(`RSTC_THR_OFS, 32'h55);
    rd(`RSTC_CTRL_OFS, 32'h2);
    chk(idle_sysclk_keep_q, 1'b0);
    wr(`RSTC_CTRL_OFS, 32'h0);
    wr(`RSTC_WATCHDOG_CONTROL_REG_OFS, 32'h03);
    settle();
    chk(rst_seen, 3);
    rd(`RSTC_WATCHDOG_CONTROL_REG_OFS, 32'h53);
    rd(`RSTC_CTRL_OFS, 32'h1);
    wr(`RSTC_CTRL_OFS, 32'h0);
    $display("test code faults done");
    wr(`RSTC_WATCHDOG_CONTROL_REG_OFS, 32'hAB);
    wr(`RSTC_PORT_OFS, 32'h1234);
    wr(`RSTC_CORE_OFS, 32'h3);
    rstc_far_model_i.overflow(4);
    settle();
    chk(rst_seen, 4);
    rd(`RSTC_STAT_OFS, 32'h20);
    rd(`RSTC_WATCHDOG_CONTROL_REG_OFS, 32'h53);
    rd(`RSTC_PORT_OFS, 32'hFFFF);
    rd(`RSTC_CORE_OFS, 32'h0);
    @(posedge pclk) halt_exec <= 1'b1;
    @(posedge pclk) halt_exec <= 1'b0;
    rd(`RSTC_STAT_OFS, 32'h30);
    @(posedge pclk) wdt_clear_exec <= 1'b1;
    @(posedge pclk) wdt_clear_exec <= 1'b0;
    rd(`RSTC_STAT_OFS, 32'h20);
    wr(`RSTC_WATCHDOG_CONTROL_REG_OFS, 32'hAB);
    wr(`RSTC_PORT_OFS, 32'h1234);
    sleep_idle <= 1'b1;
    rstc_far_model_i.overflow(4);
    settle();
    sleep_idle <= 1'b0;
    chk(rst_seen, 4);
    chk(pulse_seen, 1);
    rd(`RSTC_STAT_OFS, 32'h30);
    rd(`RSTC_WATCHDOG_CONTROL_REG_OFS, 32'hAB);
    rd(`RSTC_PORT_OFS, 32'h1234);
    @(posedge pclk) wdt_clear_exec <= 1'b1;
    @(posedge pclk) wdt_clear_exec <= 1'b0;
    rd(`RSTC_STAT_OFS, 32'h20);
    $display("test watchdog done");
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RSTC_STAT_OFS, 32'h0);
    rd(`RSTC_PORT_OFS, 32'hFFFF);
    $display("test second power-on done");
    print_verdict();
  end
endmodule
